// >>> inc/ods_regs.vh
// constants for the operation data sequencer
`ifndef ODS_REGS_VH
`define ODS_REGS_VH
`define ODS_CLK_NS 40
`define ODS_MS_NS 1000000
`define ODS_LINK_NONE 2'h0
`define ODS_LINK_MANUAL 2'h1
`define ODS_LINK_AUTO 2'h2
`define ODS_LINK_CONT 2'h3
`define ODS_NEXT_STOP 9'h100
`define ODS_NEXT_PLUS2 9'h1fe
`define ODS_NEXT_PLUS1 9'h1ff
`define ODS_TRG_OFF 4'h0
`define ODS_TRG_ON_CALC 4'h1
`define ODS_TRG_ON_MS 4'h2
`define ODS_TRG_OFF_CALC 4'h3
`define ODS_TRG_OFF_MS 4'h4
`define ODS_TRG_ON_EDGE 4'h5
`define ODS_TRG_OFF_EDGE 4'h6
`define ODS_TRG_ON_CUM 4'h7
`define ODS_TRG_OFF_CUM 4'h8
`define ODS_IO_W 16
`define ODS_CUR_MAX 10'h3e8
`define ODS_AREA_OFF_W 32'hffffffff
`endif

// >>> hdl/ods_evt_trig.v
// event trigger detector for one operation I/O event
`timescale 1ns/100ps
`include "ods_regs.vh"
module ods_evt_trig (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // control
  input wire armed,
  input wire ms_tick,
  // event setup
  input wire [7:0] src,
  input wire [3:0] typ,
  input wire [15:0] cnt,
  // synchronised trigger I/O lines
  input wire [`ODS_IO_W-1:0] io_sync,
  // detection
  output wire fire
);
  reg [15:0] acc_ff;
  reg [15:0] nxt_acc;
  reg done_ff;
  reg nxt_done;
  reg lvl_d_ff;
  reg lvl;
  reg is_off;
  reg is_edge;
  reg is_cum;
  reg hit;
  wire [7:0] idx;

  assign idx = src - 8'h01;

  always @*
  begin
    is_off = (typ == `ODS_TRG_OFF_CALC) || (typ == `ODS_TRG_OFF_MS) ||
             (typ == `ODS_TRG_OFF_EDGE) || (typ == `ODS_TRG_OFF_CUM);
    is_edge = (typ == `ODS_TRG_ON_EDGE) || (typ == `ODS_TRG_OFF_EDGE);
    is_cum = (typ == `ODS_TRG_ON_CALC) || (typ == `ODS_TRG_OFF_CALC) ||
             (typ == `ODS_TRG_ON_CUM) || (typ == `ODS_TRG_OFF_CUM);
    lvl = 1'b0;
    if (src != 8'h00 && src <= `ODS_IO_W)
      lvl = io_sync[idx[3:0]] ^ is_off;
    hit = 1'b0;
    nxt_acc = acc_ff;
    if (is_edge)
    begin
      if (lvl && !lvl_d_ff)
      begin
        nxt_acc = acc_ff + 16'h0001;
        hit = (nxt_acc >= cnt);
      end
    end
    else
    begin
      // plain ms types restart when the level drops, cumulative ones keep counting
      if (!lvl && !is_cum)
        nxt_acc = 16'h0000;
      else if (lvl && ms_tick && acc_ff != 16'hffff)
        nxt_acc = acc_ff + 16'h0001;
      hit = lvl && (acc_ff >= cnt);
    end
    if (typ == `ODS_TRG_OFF || typ > `ODS_TRG_OFF_CUM)
      hit = 1'b0;
    nxt_done = done_ff | hit;
    if (!armed)
    begin
      nxt_acc = 16'h0000;
      nxt_done = 1'b0;
    end
  end

  assign fire = armed && hit && !done_ff;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_ff <= 16'h0000;
      done_ff <= 1'b0;
      lvl_d_ff <= 1'b0;
    end
    else
    begin
      acc_ff <= nxt_acc;
      done_ff <= nxt_done;
      // edge reference follows the line even when idle, so a held level is no edge
      lvl_d_ff <= lvl;
    end
  end
endmodule // ods_evt_trig

// >>> hdl/ods_sequencer.v
// operation data sequencer: entry selection, link chaining, event jumps
`timescale 1ns/100ps
`include "ods_regs.vh"
module ods_sequencer #(
  parameter MS_CYCLES = `ODS_MS_NS / `ODS_CLK_NS
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // host pins, asynchronous
  input wire start_input,
  input wire sequential_start_input,
  input wire [7:0] direct_select_inputs,
  input wire [7:0] data_number_select_inputs,
  input wire [`ODS_IO_W-1:0] io_lines,
  // network selection, from same-clock logic
  input wire [15:0] network_selection_number,
  // configuration
  input wire dsel_start_en,
  input wire [63:0] dsel_map,
  // fields of the running entry
  input wire [1:0] ent_link,
  input wire [8:0] ent_next,
  input wire [15:0] ent_delay_ms,
  input wire [9:0] ent_op_current,
  input wire ent_push,
  input wire [31:0] ent_area_offset,
  input wire [31:0] ent_area_width,
  input wire ent_lo_evt_en,
  input wire ent_hi_evt_en,
  // fields of the entry's low event
  input wire [1:0] lo_link,
  input wire [8:0] lo_next,
  input wire [15:0] lo_dwell_ms,
  input wire [7:0] lo_src,
  input wire [3:0] lo_type,
  input wire [15:0] lo_count,
  // fields of the entry's high event
  input wire [1:0] hi_link,
  input wire [8:0] hi_next,
  input wire [15:0] hi_dwell_ms,
  input wire [7:0] hi_src,
  input wire [3:0] hi_type,
  input wire [15:0] hi_count,
  // motion profile generator
  input wire motion_done,
  input wire [31:0] motion_pos,
  output reg motion_start_ff,
  output reg motion_chain_ff,
  output reg motion_stop_req_ff,
  output reg [7:0] entry_num_ff,
  output reg [9:0] torque_limit_ff,
  // status
  output wire ready,
  output reg motion_area_output_ff
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RUN = 5'h02;
  localparam [4:0] ST_DECEL = 5'h04;
  localparam [4:0] ST_WAIT = 5'h08;
  localparam [4:0] ST_HOLD = 5'h10;

  reg [4:0] state_ff;
  reg [4:0] nxt_state;
  reg [1:0] pend_link_ff;
  reg [1:0] nxt_pend_link;
  reg [8:0] pend_next_ff;
  reg [8:0] nxt_pend_next;
  reg [15:0] wait_ms_ff;
  reg [15:0] nxt_wait_ms;
  reg [31:0] pre_ff;
  reg [31:0] nxt_pre;
  reg man_pend_ff;
  reg nxt_man_pend;
  reg [7:0] nxt_entry;
  reg nxt_start;
  reg nxt_chain;
  reg [7:0] sel_num;
  reg [2:0] dsel_idx;
  reg [8:0] go_num;
  reg go_ok;
  reg [1:0] ev_link;
  reg [8:0] ev_next;
  reg [15:0] ev_dwell;
  reg [32:0] area_hi;
  reg area_in;
  integer i;

  // two-flop synchronisers for pins
  reg start_m_ff, start_s_ff, start_d_ff;
  reg sseq_m_ff, sseq_s_ff, sseq_d_ff;
  reg [7:0] dsel_m_ff, dsel_s_ff;
  reg dsel_one_d_ff;
  reg [7:0] msel_m_ff, msel_s_ff;
  reg [`ODS_IO_W-1:0] io_m_ff, io_s_ff;

  wire ms_tick;
  wire lo_fire;
  wire hi_fire;
  wire dsel_one;
  wire start_rise;
  wire sseq_rise;
  wire dsel_rise;
  wire go_req;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      start_m_ff <= 1'b0;
      start_s_ff <= 1'b0;
      start_d_ff <= 1'b0;
      sseq_m_ff <= 1'b0;
      sseq_s_ff <= 1'b0;
      sseq_d_ff <= 1'b0;
      dsel_m_ff <= 8'h00;
      dsel_s_ff <= 8'h00;
      dsel_one_d_ff <= 1'b0;
      msel_m_ff <= 8'h00;
      msel_s_ff <= 8'h00;
      io_m_ff <= {`ODS_IO_W{1'b0}};
      io_s_ff <= {`ODS_IO_W{1'b0}};
    end
    else
    begin
      start_m_ff <= start_input;
      start_s_ff <= start_m_ff;
      start_d_ff <= start_s_ff;
      sseq_m_ff <= sequential_start_input;
      sseq_s_ff <= sseq_m_ff;
      sseq_d_ff <= sseq_s_ff;
      dsel_m_ff <= direct_select_inputs;
      dsel_s_ff <= dsel_m_ff;
      dsel_one_d_ff <= dsel_one;
      msel_m_ff <= data_number_select_inputs;
      msel_s_ff <= msel_m_ff;
      io_m_ff <= io_lines;
      io_s_ff <= io_m_ff;
    end
  end

  assign start_rise = start_s_ff && !start_d_ff;
  assign sseq_rise = sseq_s_ff && !sseq_d_ff;
  // exactly one bit set: nonzero and clearing the lowest bit leaves zero
  assign dsel_one = (dsel_s_ff != 8'h00) &&
                    ((dsel_s_ff & (dsel_s_ff - 8'h01)) == 8'h00);
  assign dsel_rise = dsel_one && !dsel_one_d_ff && dsel_start_en;
  assign ready = (state_ff == ST_IDLE) || (state_ff == ST_WAIT);
  assign go_req = start_rise || dsel_rise;

  // entry selection
  always @*
  begin
    dsel_idx = 3'h0;
    for (i = 0; i < 8; i = i + 1)
      if (dsel_s_ff[i])
        dsel_idx = i[2:0];
    if (network_selection_number[15:8] == 8'h00)
      sel_num = network_selection_number[7:0];
    else if (dsel_one)
      sel_num = dsel_map[dsel_idx*8 +: 8];
    else
      sel_num = msel_s_ff;
  end

  // next pointer decode, bit 8 set means a negative code
  function [8:0] ods_ptr;
    input [8:0] ptr;
    input [7:0] cur;
    begin
      if (!ptr[8])
        ods_ptr = {1'b1, ptr[7:0]};
      else if (ptr == `ODS_NEXT_PLUS1)
        ods_ptr = {1'b1, cur + 8'h01};
      else if (ptr == `ODS_NEXT_PLUS2)
        ods_ptr = {1'b1, cur + 8'h02};
      else
        ods_ptr = 9'h000;
    end
  endfunction

  // millisecond prescaler, free running only while timing
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pre_ff <= 32'h0;
    else
      pre_ff <= nxt_pre;
  end

  always @*
  begin
    // restart on every state change so a delay or dwell is never cut short
    if ((state_ff != ST_HOLD && state_ff != ST_RUN) || nxt_state != state_ff)
      nxt_pre = 32'h0;
    else if (pre_ff >= MS_CYCLES - 1)
      nxt_pre = 32'h0;
    else
      nxt_pre = pre_ff + 32'h1;
  end

  assign ms_tick = (pre_ff >= MS_CYCLES - 1);

  ods_evt_trig u_lo_trig (
    .clk(clk),
    .arst_n(arst_n),
    // disarmed for the chain cycle so counts of the old entry are dropped
    .armed((state_ff == ST_RUN) && ent_lo_evt_en && !motion_chain_ff),
    .ms_tick(ms_tick),
    .src(lo_src),
    .typ(lo_type),
    .cnt(lo_count),
    .io_sync(io_s_ff),
    .fire(lo_fire)
  );

  ods_evt_trig u_hi_trig (
    .clk(clk),
    .arst_n(arst_n),
    .armed((state_ff == ST_RUN) && ent_hi_evt_en && !motion_chain_ff),
    .ms_tick(ms_tick),
    .src(hi_src),
    .typ(hi_type),
    .cnt(hi_count),
    .io_sync(io_s_ff),
    .fire(hi_fire)
  );

  // sequencing
  always @*
  begin
    nxt_state = state_ff;
    nxt_pend_link = pend_link_ff;
    nxt_pend_next = pend_next_ff;
    nxt_wait_ms = wait_ms_ff;
    nxt_man_pend = man_pend_ff;
    nxt_entry = entry_num_ff;
    nxt_start = 1'b0;
    nxt_chain = 1'b0;
    if (hi_fire)
    begin
      ev_link = hi_link;
      ev_next = hi_next;
      ev_dwell = hi_dwell_ms;
    end
    else
    begin
      ev_link = lo_link;
      ev_next = lo_next;
      ev_dwell = lo_dwell_ms;
    end
    go_num = ods_ptr(pend_next_ff, entry_num_ff);
    go_ok = go_num[8];
    case (state_ff)
      ST_IDLE, ST_WAIT:
      begin
        if (go_req)
        begin
          nxt_entry = sel_num;
          nxt_start = 1'b1;
          nxt_man_pend = 1'b0;
          nxt_state = ST_RUN;
        end
        else if (sseq_rise && man_pend_ff && go_ok)
        begin
          nxt_entry = go_num[7:0];
          nxt_start = 1'b1;
          nxt_man_pend = 1'b0;
          nxt_state = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if ((hi_fire || lo_fire) && ev_link != `ODS_LINK_NONE)
        begin
          go_num = ods_ptr(ev_next, entry_num_ff);
          if (ev_link == `ODS_LINK_CONT)
          begin
            if (go_num[8])
            begin
              nxt_entry = go_num[7:0];
              nxt_chain = 1'b1;
            end
            else
              nxt_state = ST_DECEL;
            nxt_pend_link = `ODS_LINK_NONE;
            nxt_wait_ms = 16'h0000;
          end
          else
          begin
            nxt_pend_link = ev_link;
            nxt_pend_next = ev_next;
            nxt_wait_ms = ev_dwell;
            nxt_state = ST_DECEL;
          end
        end
        else if (motion_done)
        begin
          go_num = ods_ptr(ent_next, entry_num_ff);
          if (ent_link == `ODS_LINK_CONT && go_num[8])
          begin
            nxt_entry = go_num[7:0];
            nxt_chain = 1'b1;
          end
          else
          begin
            nxt_pend_link = ent_link;
            nxt_pend_next = ent_next;
            nxt_wait_ms = ent_delay_ms;
            nxt_state = ST_HOLD;
          end
        end
      end
      ST_DECEL:
      begin
        if (motion_done)
          nxt_state = ST_HOLD;
      end
      ST_HOLD:
      begin
        if (wait_ms_ff != 16'h0000)
        begin
          if (ms_tick)
            nxt_wait_ms = wait_ms_ff - 16'h0001;
        end
        else if (pend_link_ff == `ODS_LINK_AUTO && go_ok)
        begin
          nxt_entry = go_num[7:0];
          nxt_start = 1'b1;
          nxt_state = ST_RUN;
        end
        else if (pend_link_ff == `ODS_LINK_MANUAL && go_ok)
        begin
          nxt_man_pend = 1'b1;
          nxt_state = ST_WAIT;
        end
        else
          nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // area window; an all-ones width disables the output
  always @*
  begin
    area_hi = {ent_area_offset[31], ent_area_offset} +
              {ent_area_width[31], ent_area_width};
    area_in = (ent_area_width != `ODS_AREA_OFF_W) &&
              ($signed(motion_pos) >= $signed(ent_area_offset)) &&
              ($signed({motion_pos[31], motion_pos}) <= $signed(area_hi));
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= ST_IDLE;
      pend_link_ff <= `ODS_LINK_NONE;
      pend_next_ff <= `ODS_NEXT_STOP;
      wait_ms_ff <= 16'h0000;
      man_pend_ff <= 1'b0;
      entry_num_ff <= 8'h00;
      motion_start_ff <= 1'b0;
      motion_chain_ff <= 1'b0;
      motion_stop_req_ff <= 1'b0;
      torque_limit_ff <= `ODS_CUR_MAX;
      motion_area_output_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      pend_link_ff <= nxt_pend_link;
      pend_next_ff <= nxt_pend_next;
      wait_ms_ff <= nxt_wait_ms;
      man_pend_ff <= nxt_man_pend;
      entry_num_ff <= nxt_entry;
      motion_start_ff <= nxt_start;
      motion_chain_ff <= nxt_chain;
      motion_stop_req_ff <= (nxt_state == ST_DECEL);
      // limit clamps at full scale so a bad field cannot exceed base current
      if (!ent_push)
        torque_limit_ff <= `ODS_CUR_MAX;
      else if (ent_op_current > `ODS_CUR_MAX)
        torque_limit_ff <= `ODS_CUR_MAX;
      else
        torque_limit_ff <= ent_op_current;
      motion_area_output_ff <= area_in && (state_ff == ST_RUN);
    end
  end
endmodule // ods_sequencer

// >>> tb/ods_seq_monitor.sv
// concurrent checks on the sequencer top ports
`timescale 1ns/100ps
module ods_seq_monitor (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // host pins
  input wire start_input,
  input wire [7:0] direct_select_inputs,
  input wire [7:0] data_number_select_inputs,
  input wire [15:0] network_selection_number,
  // entry fields and motion
  input wire ent_push,
  input wire [9:0] ent_op_current,
  input wire [31:0] ent_area_offset,
  input wire [31:0] ent_area_width,
  input wire motion_done,
  input wire [31:0] motion_pos,
  // outputs
  input wire motion_start_ff,
  input wire motion_chain_ff,
  input wire motion_stop_req_ff,
  input wire [7:0] entry_num_ff,
  input wire [9:0] torque_limit_ff,
  input wire ready,
  input wire motion_area_output_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  start_busy_a: assert property ($rose(motion_start_ff) |-> !ready)
    else $error("ready high at start");
  start_pulse_a: assert property (motion_start_ff |=> !motion_start_ff)
    else $error("start pulse too long");
  net_select_a: assert property (motion_start_ff && start_input && $past(ready)
    && network_selection_number < 16'h0100 |-> entry_num_ff == network_selection_number[7:0])
    else $error("network number not used");
  bin_select_a: assert property (motion_start_ff && start_input && $past(ready)
    && network_selection_number > 16'h00ff && direct_select_inputs == 8'h00
    |-> entry_num_ff == data_number_select_inputs) else $error("binary select wrong");
  torque_set_a: assert property ($rose(motion_start_ff)
    |-> ##2 torque_limit_ff == (ent_push ? ent_op_current : 10'h3e8))
    else $error("torque limit wrong");
  area_range_a: assert property (motion_area_output_ff
    |-> $past(ent_area_width) != 32'hffffffff && $past(motion_pos) >= $past(ent_area_offset))
    else $error("area output out of range");
  chain_nostop_a: assert property (motion_chain_ff |-> !motion_stop_req_ff)
    else $error("chain with stop request");
  stop_hold_a: assert property (motion_stop_req_ff && !motion_done |=> motion_stop_req_ff)
    else $error("stop request dropped early");
endmodule // ods_seq_monitor
bind ods_sequencer ods_seq_monitor mon (.*);

// >>> tb/ods_host_model.sv
// host controller model driving selection and start pins
`timescale 1ns/100ps
module ods_host_model (
  // clock and status
  input wire clk,
  input wire ready,
  // pins toward the sequencer
  output logic start_input = 1'b0,
  output logic sequential_start_input = 1'b0,
  output logic [7:0] direct_select_inputs = 8'h00,
  output logic [7:0] data_number_select_inputs = 8'h00,
  output logic [15:0] network_selection_number = 16'hffff
);
  int n;
  task automatic wait_lvl(input logic lvl);
    n = 0;
    while (ready !== lvl && n < 500)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic sel_start(input [15:0] net, input [7:0] ds, input [7:0] dn, input go);
    @(negedge clk);
    network_selection_number = net;
    direct_select_inputs = ds;
    data_number_select_inputs = dn;
    // selection settles one cycle ahead of the start edge
    @(negedge clk);
    wait_lvl(1'b1);
    start_input = go;
    wait_lvl(1'b0);
    // held past the drop of ready, then scrambled to catch late latching
    repeat (2) @(negedge clk);
    start_input = 1'b0;
    data_number_select_inputs = ~dn;
  endtask
  task automatic seq_start();
    wait_lvl(1'b1);
    sequential_start_input = 1'b1;
    wait_lvl(1'b0);
    @(negedge clk);
    sequential_start_input = 1'b0;
  endtask
endmodule // ods_host_model

// >>> tb/ods_sequencer_test.sv
// self-checking bench for the operation data sequencer
`timescale 1ns/100ps
`include "ods_regs.vh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module ods_sequencer_test;
  typedef struct packed {logic [15:0] net; logic [7:0] ds, dn, ent; logic [9:0] trq;} ods_row_t;
  logic clk = 0;
  logic arst_n = 0;
  logic dsel_en = 0;
  logic [15:0] io_lines = 0;
  logic [63:0] dsel_map;
  logic [1:0] t_link [256];
  logic [8:0] t_next [256];
  logic [15:0] t_dly [256];
  logic [9:0] t_cur [256];
  logic t_push [256], t_lo [256], t_hi [256];
  logic [1:0] lo_link = 0, hi_link = 0;
  logic [8:0] lo_next = 0, hi_next = 0;
  logic [15:0] hi_dwell = 0, lo_dwell = 0, cnt = 0;
  logic [7:0] hi_src = 8'h02;
  logic mstop_q = 0;
  logic [3:0] typ = 0;
  logic [31:0] a_off = 0, a_w = 32'hffffffff, pos = 0;
  logic motion_done = 0;
  logic [7:0] mcnt = 0, run_len = 6;
  int bad_count = 0, total_checks = 0, n_start = 0, n_chain = 0, n_stop = 0, k, sp;
  wire start_input, sequential_start_input, ready, ms, mc, mstop, area;
  wire [7:0] dsel, dnum, entry;
  wire [15:0] net;
  wire [9:0] torque;
  ods_row_t rows [5] = '{
    '{16'h0005, 8'h00, 8'h00, 8'h05, 10'h3e8},
    '{16'h00ff, 8'h01, 8'h33, 8'hff, 10'h3e8},
    '{16'h0100, 8'h04, 8'h33, 8'h22, 10'h3e8},
    '{16'hffff, 8'h06, 8'h33, 8'h33, 10'h3e8},
    '{16'h8000, 8'h00, 8'ha5, 8'ha5, 10'h1f4}};
  ods_sequencer #(.MS_CYCLES(4)) dut (
    .clk(clk), .arst_n(arst_n), .start_input(start_input),
    .sequential_start_input(sequential_start_input), .direct_select_inputs(dsel),
    .data_number_select_inputs(dnum), .io_lines(io_lines), .network_selection_number(net),
    .dsel_start_en(dsel_en), .dsel_map(dsel_map), .ent_link(t_link[entry]),
    .ent_next(t_next[entry]), .ent_delay_ms(t_dly[entry]), .ent_op_current(t_cur[entry]),
    .ent_push(t_push[entry]), .ent_area_offset(a_off), .ent_area_width(a_w),
    .ent_lo_evt_en(t_lo[entry]), .ent_hi_evt_en(t_hi[entry]), .lo_link(lo_link),
    .lo_next(lo_next), .lo_dwell_ms(lo_dwell), .lo_src(8'h01), .lo_type(typ),
    .lo_count(cnt), .hi_link(hi_link), .hi_next(hi_next), .hi_dwell_ms(hi_dwell),
    .hi_src(hi_src), .hi_type(typ), .hi_count(cnt), .motion_done(motion_done),
    .motion_pos(pos), .motion_start_ff(ms), .motion_chain_ff(mc),
    .motion_stop_req_ff(mstop), .entry_num_ff(entry), .torque_limit_ff(torque),
    .ready(ready), .motion_area_output_ff(area));
  ods_host_model host (.clk(clk), .ready(ready), .start_input(start_input),
    .sequential_start_input(sequential_start_input), .direct_select_inputs(dsel),
    .data_number_select_inputs(dnum), .network_selection_number(net));
  initial forever #20 clk = ~clk;
  // motion stand-in: done after run_len cycles, within 3 on a stop request
  always @(negedge clk)
  begin
    motion_done <= 1'b0;
    if (ms || mc)
      mcnt <= run_len;
    else if (mstop && mcnt > 8'd3)
      mcnt <= 8'd3;
    else if (mcnt == 8'd1)
    begin
      motion_done <= 1'b1;
      mcnt <= 8'd0;
    end
    else if (mcnt != 8'd0)
      mcnt <= mcnt - 8'd1;
  end
  always @(posedge clk)
  begin
    n_start <= n_start + int'(ms);
    n_chain <= n_chain + int'(mc);
    n_stop <= n_stop + int'(mstop && !mstop_q);
    mstop_q <= mstop;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_ready();
    k = 0;
    while (ready !== 1'b1 && k < 2000)
    begin
      @(negedge clk);
      k++;
    end
    `CHK("ready back", 1'b1, ready)
  endtask
  task automatic run_chk(input [7:0] e, input [7:0] e_end, input int ds, input int dc,
    input [15:0] io);
    int s0, c0;
    s0 = n_start;
    c0 = n_chain;
    host.sel_start(16'hffff, 8'h00, e, 1'b1);
    repeat (4) @(negedge clk);
    io_lines = io;
    wait_ready();
    io_lines = 16'h0000;
    `CHK("end entry", e_end, entry)
    `CHK("starts", ds, n_start - s0)
    `CHK("chains", dc, n_chain - c0)
  endtask
  initial
  begin
    #(20000 * 40);
    bad_count++;
    summarize();
  end
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      t_link[i] = `ODS_LINK_NONE;
      t_next[i] = `ODS_NEXT_PLUS1;
      t_dly[i] = 16'h0000;
      t_cur[i] = 10'h000;
      {t_push[i], t_lo[i], t_hi[i]} = 3'h0;
    end
    for (int i = 0; i < 8; i++)
      dsel_map[8*i +: 8] = 8'h20 + 8'(i);
    t_push[8'ha5] = 1'b1;
    t_cur[8'ha5] = 10'h1f4;
    {t_link[10], t_dly[10]} = {`ODS_LINK_AUTO, 16'h0001};
    {t_link[20], t_next[20], t_dly[20]} = {`ODS_LINK_MANUAL, `ODS_NEXT_PLUS2, 16'h0001};
    {t_link[30], t_next[30]} = {`ODS_LINK_CONT, 9'h028};
    {t_link[50], t_next[50]} = {`ODS_LINK_AUTO, `ODS_NEXT_STOP};
    {t_lo[60], t_hi[60], t_hi[90]} = 3'h7;
    repeat (10) @(negedge clk);
    `CHK("reset ready", 1'b1, ready)
    `CHK("reset torque", `ODS_CUR_MAX, torque)
    `CHK("reset entry", 8'h00, entry)
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    foreach (rows[i])
    begin
      host.sel_start(rows[i].net, rows[i].ds, rows[i].dn, 1'b1);
      repeat (2) @(negedge clk);
      `CHK("entry", rows[i].ent, entry)
      `CHK("torque", rows[i].trq, torque)
      wait_ready();
    end
    dsel_en = 1'b1;
    host.sel_start(16'hffff, 8'h80, 8'h00, 1'b0);
    `CHK("direct start", 8'h27, entry)
    wait_ready();
    dsel_en = 1'b0;
    sp = n_start;
    host.sel_start(16'hffff, 8'h40, 8'h00, 1'b0);
    `CHK("direct only", sp, n_start)
    run_chk(8'd10, 8'd11, 2, 0, 16'h0000);
    run_chk(8'd30, 8'd40, 1, 1, 16'h0000);
    run_chk(8'd50, 8'd50, 1, 0, 16'h0000);
    run_chk(8'd20, 8'd20, 1, 0, 16'h0000);
    host.seq_start();
    wait_ready();
    `CHK("manual next", 8'd22, entry)
    run_len = 8'd40;
    {typ, cnt} = {`ODS_TRG_ON_EDGE, 16'h0001};
    {lo_link, lo_next, hi_link, hi_next} = {`ODS_LINK_CONT, 9'h046, `ODS_LINK_CONT, 9'h050};
    run_chk(8'd60, 8'd80, 1, 1, 16'h0003);
    {hi_link, hi_next, hi_dwell} = {`ODS_LINK_AUTO, 9'h05b, 16'h0001};
    sp = n_stop;
    run_chk(8'd90, 8'd91, 2, 0, 16'h0002);
    `CHK("stop request", sp + 1, n_stop)
    // high source unassigned while line 16 is on; low ms event waits for sequential start
    {typ, cnt, hi_src, lo_dwell} = {`ODS_TRG_ON_MS, 16'h0002, 8'h00, 16'h0001};
    {lo_link, lo_next} = {`ODS_LINK_MANUAL, 9'h05d};
    run_chk(8'd60, 8'd60, 1, 0, 16'h8001);
    host.seq_start();
    wait_ready();
    `CHK("event next", 8'h5d, entry)
    {a_off, a_w, pos} = {32'd100, 32'd50, 32'd120};
    host.sel_start(16'hffff, 8'h00, 8'h00, 1'b1);
    `CHK("area in", 1'b1, area)
    pos = 32'd200;
    repeat (3) @(negedge clk);
    `CHK("area out", 1'b0, area)
    wait_ready();
    summarize();
  end
endmodule // ods_sequencer_test
